// ==== verilog/wdt_pkg.sv ====
// Constants and types shared by the indexed-port watchdog
// How it works
// R1 - Two host I/O ports are decoded: 2e selects a register index and 2f carries that register's data.
// R2 - The host writes the register number to the index port before it reads or writes that register through the data port.
// R3 - Configuration access opens only after 87 is written to the index port twice in a row, and data accesses are ignored before that.
// R4 - Writing aa to the index port closes configuration access again.
// R5 - Writing 08 to the logical-device select register at index 07 routes later accesses to the watchdog registers.
// R6 - Writing 01 to the activation register at index 30 turns the watchdog on, and it is off after reset.
// R7 - Bit 3 of the unit register at f5 picks the counting unit: 0 is seconds and the reset value, 1 is minutes.
// R8 - The count register at f6 resets to zero, zero holds the timer stopped, and 01 to ff set the timeout length.
// R9 - A running timer waits the programmed count for a restart and raises its timeout output if none comes.
// R10 - Every write to the count register restarts the countdown from the written value.
// R11 - The timeout range is 1 to 255 units of one second or one minute.
// R12 - With bit 7 of the control register at f7 set, mouse activity restarts the timer; it resets to 0.
// R13 - With bit 6 of the control register set, keyboard activity restarts the timer; it resets to 0.
// R14 - Writing 1 to bit 5 of the control register forces a timeout at once, and the bit clears itself.
// R15 - Bit 4 of the control register reads 1 once the watchdog has timed out.
// R16 - The running count drops by one per unit tick, and reaching zero signals timeout and sets the status bit.
package wdt_pkg;

    // ------------------------------------------------------------
    // Host ports and key values
    // ------------------------------------------------------------
    localparam logic [15:0] INDEX_PORT = 16'h002e;
    localparam logic [15:0] DATA_PORT = 16'h002f;
    localparam logic [7:0] UNLOCK_KEY = 8'h87;
    localparam logic [7:0] LOCK_KEY = 8'haa;
    localparam logic [7:0] WDT_DEVICE = 8'h08;
    localparam logic [7:0] ACTIVATE_VALUE = 8'h01;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [7:0] REG_LOGICAL_DEVICE_SELECT = 8'h07;
    localparam logic [7:0] REG_FUNCTION_ACTIVATE = 8'h30;
    localparam logic [7:0] REG_COUNT_UNIT_SELECT = 8'hf5;
    localparam logic [7:0] REG_TIMEOUT_COUNT = 8'hf6;
    localparam logic [7:0] REG_RESTART_CONTROL_STATUS = 8'hf7;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int UNIT_MINUTES_BIT = 3;
    localparam int MOUSE_RESTART_BIT = 7;
    localparam int KBD_RESTART_BIT = 6;
    localparam int FORCE_TIMEOUT_BIT = 5;
    localparam int TIMEOUT_STATUS_BIT = 4;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int SECOND_S = 1;
    localparam int SECOND_CYCLES = CLK_HZ * SECOND_S;
    localparam int MINUTE_SECONDS = 60;

    typedef enum logic [2:0] {
        LK_LOCKED = 3'b001,
        LK_HALF = 3'b010,
        LK_OPEN = 3'b100
    } lock_state_t;

endpackage

// ==== verilog/wdt_tick_if.sv ====
// Interface carrying the time base between watchdog modules
`timescale 1ns/10ps
`default_nettype none
interface wdt_tick_if;
    logic run;
    logic minutes;
    logic tick;
    modport base (input run, input minutes, output tick);
    modport core (output run, output minutes, input tick);
endinterface
`default_nettype wire

// ==== verilog/wdt_time_base.sv ====
// Seconds and minutes tick divider for the watchdog
`timescale 1ns/10ps
`default_nettype none
module wdt_time_base #(
    parameter int SEC_CYCLES = 200_000_000,
    parameter int MIN_SECS = 60
) (
    input wire logic ref_clk,
    input wire logic nrst,
    wdt_tick_if.base tb
);
    // Refuse dividers that cannot produce a one-cycle tick
    if (SEC_CYCLES < 2 || MIN_SECS < 1 || MIN_SECS > 255) begin : g_bad_params
        $error("wdt_time_base: bad divider parameters");
    end

    logic [31:0] cyc;
    logic [7:0] secs;
    logic tick_r;
    logic [31:0] next_cyc;
    logic [7:0] next_secs;
    logic next_tick;

    assign tb.tick = tick_r;

    // ------------------------------------------------------------
    // Divider, restarts whenever the timer is stopped
    // ------------------------------------------------------------
    always_comb begin
        next_cyc = cyc;
        next_secs = secs;
        next_tick = 1'b0;
        if (!tb.run) begin
            next_cyc = '0;
            next_secs = '0;
        end else if (cyc == 32'(SEC_CYCLES - 1)) begin
            next_cyc = '0;
            if (!tb.minutes || secs == 8'(MIN_SECS - 1)) begin
                next_secs = '0;
                next_tick = 1'b1;
            end else begin
                next_secs = secs + 8'h01;
            end
        end else begin
            next_cyc = cyc + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cyc <= '0;
            secs <= '0;
            tick_r <= 1'b0;
        end else begin
            cyc <= next_cyc;
            secs <= next_secs;
            tick_r <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/indexed_port_watchdog.sv ====
// Watchdog timer behind an index/data I/O port pair
`timescale 1ns/10ps
`default_nettype none
module indexed_port_watchdog #(
    parameter int SEC_CYCLES = wdt_pkg::SECOND_CYCLES
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    input wire logic mouse_act,
    input wire logic kbd_act,
    output logic wdt_timeout
);
    import wdt_pkg::*;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // A divider shorter than two cycles cannot produce a one-cycle tick
    if (SEC_CYCLES < 2) begin : g_bad_sec_cycles
        $error("indexed_port_watchdog: SEC_CYCLES too small");
    end

    // ------------------------------------------------------------
    // Pin synchronisers for activity inputs
    // ------------------------------------------------------------
    // Activity pins are asynchronous: two stages before the edge detector
    logic [1:0] mouse_sync;
    logic [1:0] kbd_sync;
    logic mouse_q;
    logic kbd_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mouse_sync <= 2'b00;
            kbd_sync <= 2'b00;
            mouse_q <= 1'b0;
            kbd_q <= 1'b0;
        end else begin
            mouse_sync <= {mouse_sync[0], mouse_act};
            kbd_sync <= {kbd_sync[0], kbd_act};
            mouse_q <= mouse_sync[1];
            kbd_q <= kbd_sync[1];
        end
    end
    // Rising edges only; idle low matches the reset value of the flops
    wire logic mouse_edge = mouse_sync[1] & ~mouse_q;
    wire logic kbd_edge = kbd_sync[1] & ~kbd_q;

    // ------------------------------------------------------------
    // Port decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
        hit = (a == p);
    endfunction

    // Other addresses are ignored and never answered
    // R1 index data decode
    wire logic idx_wr = io_wr & hit(io_addr, INDEX_PORT);
    wire logic dat_wr = io_wr & hit(io_addr, DATA_PORT);
    wire logic idx_rd = io_rd & hit(io_addr, INDEX_PORT);
    wire logic dat_rd = io_rd & hit(io_addr, DATA_PORT);

    // ------------------------------------------------------------
    // Lock, index and device select
    // ------------------------------------------------------------
    lock_state_t lock_st;
    lock_state_t next_lock_st;
    logic [7:0] index;
    logic [7:0] next_index;
    logic [7:0] ldev;
    logic [7:0] next_ldev;

    always_comb begin
        next_lock_st = lock_st;
        next_index = index;
        next_ldev = ldev;
        case (lock_st)
            LK_LOCKED: begin
                // R3 first key
                if (idx_wr) begin
                    next_lock_st = (io_wdata == UNLOCK_KEY) ? LK_HALF : LK_LOCKED;
                end
            end
            LK_HALF: begin
                // Any other index value drops back to locked
                // R3 second key
                if (idx_wr) begin
                    next_lock_st = (io_wdata == UNLOCK_KEY) ? LK_OPEN : LK_LOCKED;
                end
            end
            LK_OPEN: begin
                if (idx_wr) begin
                    // R4 lock key
                    if (io_wdata == LOCK_KEY) begin
                        next_lock_st = LK_LOCKED;
                    end else begin
                        // R2 index latched
                        next_index = io_wdata;
                    end
                end
                // R5 device select
                if (dat_wr && index == REG_LOGICAL_DEVICE_SELECT) begin
                    next_ldev = io_wdata;
                end
            end
            default: begin
                next_lock_st = LK_LOCKED;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lock_st <= LK_LOCKED;
            index <= 8'h00;
            ldev <= 8'h00;
        end else begin
            lock_st <= next_lock_st;
            index <= next_index;
            ldev <= next_ldev;
        end
    end

    // Only the logical-device select stays reachable for other devices
    // R5 watchdog routed
    wire logic wdt_sel = (lock_st == LK_OPEN) && (ldev == WDT_DEVICE);
    wire logic wr_ok = dat_wr & wdt_sel;

    // Data-port write landing on one watchdog register
    function automatic logic reg_wr(input logic ok, input logic [7:0] cur, input logic [7:0] r);
        reg_wr = ok && (cur == r);
    endfunction

    wire logic wr_act = reg_wr(wr_ok, index, REG_FUNCTION_ACTIVATE);
    wire logic wr_unit = reg_wr(wr_ok, index, REG_COUNT_UNIT_SELECT);
    wire logic wr_count = reg_wr(wr_ok, index, REG_TIMEOUT_COUNT);
    wire logic wr_ctl = reg_wr(wr_ok, index, REG_RESTART_CONTROL_STATUS);

    // ------------------------------------------------------------
    // Watchdog registers and countdown
    // ------------------------------------------------------------
    // Run and unit go to the divider, the unit tick comes back
    wdt_tick_if tick_bus ();

    logic active;
    logic minutes;
    logic mouse_en;
    logic kbd_en;
    logic [7:0] load;
    logic [7:0] count;
    logic expired;
    logic next_active;
    logic next_minutes;
    logic next_mouse_en;
    logic next_kbd_en;
    logic [7:0] next_load;
    logic [7:0] next_count;
    logic next_expired;
    logic restart;

    always_comb begin
        next_active = active;
        next_minutes = minutes;
        next_mouse_en = mouse_en;
        next_kbd_en = kbd_en;
        next_load = load;
        next_count = count;
        next_expired = expired;
        // R12 mouse restart
        // R13 keyboard restart
        restart = (mouse_en & mouse_edge) | (kbd_en & kbd_edge);
        // R6 activation write
        if (wr_act) begin
            next_active = (io_wdata == ACTIVATE_VALUE);
        end
        // R7 unit select
        if (wr_unit) begin
            next_minutes = io_wdata[UNIT_MINUTES_BIT];
        end
        if (wr_ctl) begin
            next_mouse_en = io_wdata[MOUSE_RESTART_BIT];
            next_kbd_en = io_wdata[KBD_RESTART_BIT];
        end
        // R16 tick decrement
        if (active && count != 8'h00 && tick_bus.tick) begin
            next_count = count - 8'h01;
        end
        // Activity reloads the last count written; the divider phase is kept
        if (restart && active && load != 8'h00) begin
            next_count = load;
        end
        // R10 write restarts
        // R11 range 1 to 255
        if (wr_count) begin
            next_load = io_wdata;
            next_count = io_wdata;
            next_expired = 1'b0;
        end
        // R9 timeout on expiry
        // Expiry in the cycle of a count write still sets the status
        if (active && tick_bus.tick && count == 8'h01) begin
            next_expired = 1'b1;
        end
        // R14 forced timeout
        if (wr_ctl && io_wdata[FORCE_TIMEOUT_BIT]) begin
            next_expired = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            active <= 1'b0;
            minutes <= 1'b0;
            mouse_en <= 1'b0;
            kbd_en <= 1'b0;
            load <= COUNT_RESET;
            count <= COUNT_RESET;
            expired <= 1'b0;
        end else begin
            active <= next_active;
            minutes <= next_minutes;
            mouse_en <= next_mouse_en;
            kbd_en <= next_kbd_en;
            load <= next_load;
            count <= next_count;
            expired <= next_expired;
        end
    end

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    // The divider holds reset while stopped, so the first tick is a full unit away
    // R8 zero holds stopped
    assign tick_bus.run = active & (count != 8'h00);
    assign tick_bus.minutes = minutes;

    wdt_time_base #(
        .SEC_CYCLES(SEC_CYCLES),
        .MIN_SECS(MINUTE_SECONDS)
    ) u_base (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tb(tick_bus.base)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rd_val;
    logic [7:0] next_rdata;
    logic next_rvalid;

    always_comb begin
        // Unknown indices read zero
        rd_val = READ_ZERO;
        case (index)
            REG_LOGICAL_DEVICE_SELECT: rd_val = ldev;
            REG_FUNCTION_ACTIVATE: rd_val = {7'h00, active};
            REG_COUNT_UNIT_SELECT: rd_val = 8'(minutes) << UNIT_MINUTES_BIT;
            REG_TIMEOUT_COUNT: rd_val = count;
            REG_RESTART_CONTROL_STATUS: begin
                rd_val[MOUSE_RESTART_BIT] = mouse_en;
                rd_val[KBD_RESTART_BIT] = kbd_en;
                // R15 expiry status
                rd_val[TIMEOUT_STATUS_BIT] = expired;
            end
            default: rd_val = READ_ZERO;
        endcase
        // Both ports answer; locked reads, and unrouted reads of any index but 07, return zero
        next_rvalid = idx_rd | dat_rd;
        next_rdata = READ_ZERO;
        if (dat_rd && lock_st == LK_OPEN) begin
            if (index == REG_LOGICAL_DEVICE_SELECT || wdt_sel) begin
                next_rdata = rd_val;
            end
        end else if (idx_rd && lock_st == LK_OPEN) begin
            next_rdata = index;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= READ_ZERO;
            io_rvalid <= 1'b0;
        end else begin
            io_rdata <= next_rdata;
            io_rvalid <= next_rvalid;
        end
    end

    // ------------------------------------------------------------
    // Timeout output
    // ------------------------------------------------------------
    // Registered level; stays up until a count write or reset
    assign wdt_timeout = expired;
endmodule
`default_nettype wire

// ==== tb/host.sv ====
// Host model issuing I/O port cycles to the watchdog
`timescale 1ns/10ps
`default_nettype none
module host (
    input wire logic ref_clk,
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid
);
    import wdt_pkg::*;
    initial begin
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // Released lines show the inverse of the last value
    task automatic wr(input logic [15:0] a, input logic [7:0] x);
        @(negedge ref_clk);
        io_addr = a;
        io_wdata = x;
        io_wr = 1'b1;
        @(negedge ref_clk);
        io_wr = 1'b0;
        io_addr = ~a;
        io_wdata = ~x;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] x, output logic v);
        @(negedge ref_clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge ref_clk);
        io_rd = 1'b0;
        io_addr = ~a;
        x = io_rdata;
        v = io_rvalid;
    endtask
    task automatic cfg(input logic [7:0] i, input logic [7:0] x);
        wr(INDEX_PORT, i);
        wr(DATA_PORT, x);
    endtask
endmodule
`default_nettype wire

// ==== tb/indexed_port_watchdog_monitor.sv ====
// Concurrent checks on the watchdog's host ports and timeout output
`timescale 1ns/10ps
`default_nettype none
module indexed_port_watchdog_monitor #(
    parameter int SEC_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid,
    input wire logic mouse_act,
    input wire logic kbd_act,
    input wire logic wdt_timeout
);
    import wdt_pkg::*;
    logic port_rd, data_wr, idx_wr, half, open, ever_open;
    assign port_rd = io_rd && (io_addr == INDEX_PORT || io_addr == DATA_PORT);
    assign data_wr = io_wr && io_addr == DATA_PORT;
    assign idx_wr = io_wr && io_addr == INDEX_PORT;
    // Shadow of the key sequence
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            half <= 1'b0;
            open <= 1'b0;
            ever_open <= 1'b0;
        end else begin
            ever_open <= ever_open || open;
            if (idx_wr) begin
                half <= !half && !open && io_wdata == UNLOCK_KEY;
                open <= open ? io_wdata != LOCK_KEY : half && io_wdata == UNLOCK_KEY;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_rd_answer;
        port_rd |=> io_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_rvalid_cause;
        io_rvalid |-> $past(port_rd);
    endproperty
    a_rvalid_cause: assert property (p_rvalid_cause)
        else $error("answer without read");
    property p_rdata_idle;
        !io_rvalid |-> io_rdata == READ_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero when idle");
    property p_locked_read;
        port_rd && !open |=> io_rdata == READ_ZERO;
    endproperty
    a_locked_read: assert property (p_locked_read)
        else $error("locked read not zero");
    property p_lock_key;
        idx_wr && io_wdata == LOCK_KEY ##[1:2] port_rd |=> io_rdata == READ_ZERO;
    endproperty
    a_lock_key: assert property (p_lock_key)
        else $error("read after lock not zero");
    property p_expired_holds;
        wdt_timeout && !(data_wr && open) |=> wdt_timeout;
    endproperty
    a_expired_holds: assert property (p_expired_holds)
        else $error("timeout dropped without count write");
    property p_clear_cause;
        $fell(wdt_timeout) |-> $past(data_wr) || $past(data_wr, 2);
    endproperty
    a_clear_cause: assert property (p_clear_cause)
        else $error("timeout cleared without data write");
    property p_needs_unlock;
        !ever_open |-> !wdt_timeout;
    endproperty
    a_needs_unlock: assert property (p_needs_unlock)
        else $error("timeout before any unlock");
    c_expire: cover property ($rose(wdt_timeout));
    c_clear: cover property ($fell(wdt_timeout));
    c_open_read: cover property (io_rvalid && open);
    c_mouse_act: cover property ($rose(mouse_act) && !wdt_timeout);
    c_kbd_act: cover property ($rose(kbd_act) && !wdt_timeout);
endmodule
bind indexed_port_watchdog indexed_port_watchdog_monitor #(.SEC_CYCLES(SEC_CYCLES)) indexed_port_watchdog_monitor_i (
    .ref_clk(ref_clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .mouse_act(mouse_act), .kbd_act(kbd_act),
    .wdt_timeout(wdt_timeout));
`default_nettype wire

// ==== tb/indexed_port_watchdog_test.sv ====
// Self-checking bench for the indexed-port watchdog
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module indexed_port_watchdog_test;
    import wdt_pkg::*;
    logic ref_clk, nrst, io_wr, io_rd, io_rvalid, mouse_act, kbd_act, wdt_timeout, v;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, d;
    int n_fail, comparisons;
    indexed_port_watchdog #(.SEC_CYCLES(20)) indexed_port_watchdog_i (.ref_clk(ref_clk), .nrst(nrst),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .mouse_act(mouse_act), .kbd_act(kbd_act), .wdt_timeout(wdt_timeout));
    host host_i (.ref_clk(ref_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid));
    task automatic stop_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic rr(input string n, input logic [7:0] i, input logic [7:0] e);
        host_i.wr(INDEX_PORT, i);
        host_i.rd(DATA_PORT, d, v);
        `CHK(n, e, d)
    endtask
    // Timeout must stay low lo cycles, then rise before hi
    task automatic expire(input int lo, input int hi);
        int i;
        repeat (lo) @(negedge ref_clk);
        `CHK("early", 1'b0, wdt_timeout)
        for (i = lo; i < hi && wdt_timeout !== 1'b1; i++) @(negedge ref_clk);
        `CHK("expiry", 1'b1, wdt_timeout)
        if (wdt_timeout !== 1'b1) stop_test();
    endtask
    task automatic pulse(input logic m, input logic k, input int n);
        repeat (n) begin
            repeat (30) @(negedge ref_clk);
            mouse_act = m;
            kbd_act = k;
            repeat (3) @(negedge ref_clk);
            mouse_act = 1'b0;
            kbd_act = 1'b0;
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        stop_test();
    end
    initial begin
        nrst = 1'b0;
        mouse_act = 1'b0;
        kbd_act = 1'b0;
        n_fail = 0;
        comparisons = 0;
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        host_i.rd(INDEX_PORT, d, v);
        `CHK("idx_locked", 8'h00, d)
        `CHK("rvalid", 1'b1, v)
        host_i.rd(16'h0030, d, v);
        `CHK("other_port", 1'b0, v)
        host_i.wr(INDEX_PORT, UNLOCK_KEY);
        host_i.wr(INDEX_PORT, 8'h01);
        host_i.wr(INDEX_PORT, UNLOCK_KEY);
        host_i.rd(DATA_PORT, d, v);
        `CHK("half_key", 8'h00, d)
        host_i.wr(INDEX_PORT, UNLOCK_KEY);
        host_i.cfg(REG_LOGICAL_DEVICE_SELECT, WDT_DEVICE);
        host_i.rd(INDEX_PORT, d, v);
        `CHK("idx_open", 8'h07, d)
        host_i.cfg(REG_FUNCTION_ACTIVATE, ACTIVATE_VALUE);
        rr("act", REG_FUNCTION_ACTIVATE, 8'h01);
        rr("unit_rst", REG_COUNT_UNIT_SELECT, 8'h00);
        rr("ctl_rst", REG_RESTART_CONTROL_STATUS, 8'h00);
        host_i.cfg(REG_COUNT_UNIT_SELECT, 8'hff);
        rr("unit", REG_COUNT_UNIT_SELECT, 8'h08);
        host_i.cfg(REG_COUNT_UNIT_SELECT, 8'h00);
        host_i.cfg(REG_TIMEOUT_COUNT, 8'h03);
        expire(55, 75);
        rr("status", REG_RESTART_CONTROL_STATUS, 8'h10);
        host_i.cfg(REG_TIMEOUT_COUNT, 8'h03);
        `CHK("cleared", 1'b0, wdt_timeout)
        repeat (30) @(negedge ref_clk);
        host_i.cfg(REG_TIMEOUT_COUNT, 8'h03);
        repeat (30) @(negedge ref_clk);
        `CHK("restart", 1'b0, wdt_timeout)
        host_i.cfg(REG_TIMEOUT_COUNT, 8'h00);
        repeat (100) @(negedge ref_clk);
        `CHK("stopped", 1'b0, wdt_timeout)
        host_i.cfg(REG_RESTART_CONTROL_STATUS, 8'h20);
        repeat (2) @(negedge ref_clk);
        `CHK("forced", 1'b1, wdt_timeout)
        rr("force_clr", REG_RESTART_CONTROL_STATUS, 8'h10);
        host_i.cfg(REG_RESTART_CONTROL_STATUS, 8'h80);
        host_i.cfg(REG_TIMEOUT_COUNT, 8'h03);
        pulse(1'b1, 1'b0, 5);
        `CHK("mouse_on", 1'b0, wdt_timeout)
        expire(35, 75);
        host_i.cfg(REG_RESTART_CONTROL_STATUS, 8'h40);
        host_i.cfg(REG_TIMEOUT_COUNT, 8'h03);
        pulse(1'b0, 1'b1, 5);
        `CHK("kbd_on", 1'b0, wdt_timeout)
        pulse(1'b1, 1'b0, 3);
        `CHK("mouse_off", 1'b1, wdt_timeout)
        host_i.cfg(REG_RESTART_CONTROL_STATUS, 8'h00);
        host_i.cfg(REG_COUNT_UNIT_SELECT, 8'h08);
        host_i.cfg(REG_TIMEOUT_COUNT, 8'h01);
        expire(1150, 1240);
        host_i.cfg(REG_LOGICAL_DEVICE_SELECT, 8'h00);
        rr("ldev", REG_COUNT_UNIT_SELECT, 8'h00);
        host_i.cfg(REG_TIMEOUT_COUNT, 8'h02);
        `CHK("ldev_wr", 1'b1, wdt_timeout)
        host_i.cfg(REG_LOGICAL_DEVICE_SELECT, WDT_DEVICE);
        host_i.cfg(REG_FUNCTION_ACTIVATE, 8'h00);
        host_i.cfg(REG_TIMEOUT_COUNT, 8'h02);
        repeat (100) @(negedge ref_clk);
        `CHK("disabled", 1'b0, wdt_timeout)
        host_i.wr(INDEX_PORT, LOCK_KEY);
        host_i.rd(DATA_PORT, d, v);
        `CHK("locked", 8'h00, d)
        stop_test();
    end
endmodule
`default_nettype wire
